// ==== bench/hcs_assertions.sv ====
`default_nettype none
// Checks on the decoder's outputs, seen only through its ports
module hcs_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic software_mode_i,
  input wire logic parallel_bridge_mode_i,
  input wire logic channel_slot_i,
  input wire logic sleep_active_i,
  input wire logic output_switching_i,
  input wire logic output_highz_i,
  input wire logic signal_path_active_i,
  input wire logic [7:0] ramp_level_i,
  input wire logic [1:0] analog_gain_sel_i,
  input wire logic [7:0] analog_gain_dbv_x10_i,
  input wire logic [3:0] digital_boost_db_i,
  input wire logic [7:0] volume_db_i,
  input wire logic freq_strap_high_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  right_slot_a: assert property (
    parallel_bridge_mode_i && !software_mode_i |-> channel_slot_i == hcs_pkg::SLOT_RIGHT)
    else $error("bridge mode not fed from right slot");
  fixed_boost_a: assert property (
    !software_mode_i |-> digital_boost_db_i == hcs_pkg::BOOST_FIXED_DB)
    else $error("digital boost moved");
  unity_volume_a: assert property (
    !software_mode_i |-> volume_db_i == hcs_pkg::VOLUME_UNITY_DB)
    else $error("volume left unity");
  quiet_highz_a: assert property (
    output_highz_i |-> !output_switching_i && ramp_level_i == 8'h00)
    else $error("output switching in high impedance");
  path_alive_a: assert property (
    sleep_active_i |-> signal_path_active_i)
    else $error("signal path stopped in sleep");
  software_straps_a: assert property (
    software_mode_i |-> !parallel_bridge_mode_i && !freq_strap_high_i && !sleep_active_i)
    else $error("strap still used in software mode");
  gain_legal_a: assert property (
    analog_gain_sel_i != 2'h3)
    else $error("illegal gain selection");
  gain_value_a: assert property (
    analog_gain_sel_i == hcs_pkg::AGAIN_SEL_MID |-> analog_gain_dbv_x10_i == hcs_pkg::AGAIN_MID_DBV_X10)
    else $error("gain value does not match selection");
  // Main scenarios reached
  bridge_seen_c: cover property (parallel_bridge_mode_i && !software_mode_i);
  highz_seen_c: cover property (output_highz_i && sleep_active_i);
  software_seen_c: cover property (software_mode_i);
  ramp_seen_c: cover property (sleep_active_i && output_switching_i);
endmodule // hcs_chk

bind hcs_strap_decoder hcs_chk u_chk (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .software_mode_i(software_mode_o),
  .parallel_bridge_mode_i(parallel_bridge_mode_o),
  .channel_slot_i(channel_slot_o),
  .sleep_active_i(sleep_active_o),
  .output_switching_i(output_switching_o),
  .output_highz_i(output_highz_o),
  .signal_path_active_i(signal_path_active_o),
  .ramp_level_i(ramp_level_o),
  .analog_gain_sel_i(analog_gain_sel_o),
  .analog_gain_dbv_x10_i(analog_gain_dbv_x10_o),
  .digital_boost_db_i(digital_boost_db_o),
  .volume_db_i(volume_db_o),
  .freq_strap_high_i(freq_strap_high_o)
);
`default_nettype wire

// ==== bench/hcs_board.sv ====
`default_nettype none
// Host side of the strap pins: board straps or a control processor
module hcs_board (
  input wire logic [4:0] straps_i,
  input wire logic audio_stop_i,
  input wire logic left_wanted_i,
  output logic [4:0] pins_o,
  output logic frame_select_invert_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // host raises sleep before it stops the audio
  assign pins_o = {straps_i[4:3], straps_i[2] | audio_stop_i, straps_i[1:0]};
  // host inverts frame clock for other channel
  assign frame_select_invert_o = straps_i[4] & ~(&straps_i[1:0]) & left_wanted_i;
endmodule // hcs_board
`default_nettype wire

// ==== bench/tb.sv ====
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Ramp length used by this bench and the level it ends at
  localparam int BENCH_RAMP = 4;
  localparam logic [7:0] RAMP_FULL_EXP = 8'h04;
  // Clock, reset and host controls
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic [4:0] straps = 5'h00;
  logic audio_stop = 1'h0;
  logic left_wanted = 1'h0;
  // Pins as the board presents them
  wire logic [4:0] pins;
  wire logic frame_invert;
  // Design outputs
  wire logic sw;
  wire logic pb;
  wire logic slot;
  wire logic sleep_act;
  wire logic switching;
  wire logic highz;
  wire logic path_act;
  wire logic freq_hi;
  wire logic scl;
  wire logic sda;
  wire logic [7:0] level;
  wire logic [7:0] dbv;
  wire logic [7:0] volume;
  wire logic [1:0] gsel;
  wire logic [3:0] boost;
  // Mismatch and comparison counters
  int n_fail = 0;
  int n_checks = 0;

  // Host model at the far side of the pins
  hcs_board board (
    .straps_i(straps),
    .audio_stop_i(audio_stop),
    .left_wanted_i(left_wanted),
    .pins_o(pins),
    .frame_select_invert_o(frame_invert)
  );

  // Block under test
  hcs_strap_decoder #(.RAMP_LEN(BENCH_RAMP)) dut (
    .clock_i(clock),
    .rst_i(rst),
    .bridge_mode_clock_pin_i(pins[4]),
    .frequency_data_pin_i(pins[3]),
    .sleep_address_pin_i(pins[2]),
    .gain_select_pins_i(pins[1:0]),
    .software_mode_o(sw),
    .parallel_bridge_mode_o(pb),
    .channel_slot_o(slot),
    .sleep_active_o(sleep_act),
    .output_switching_o(switching),
    .output_highz_o(highz),
    .signal_path_active_o(path_act),
    .ramp_level_o(level),
    .analog_gain_sel_o(gsel),
    .analog_gain_dbv_x10_o(dbv),
    .digital_boost_db_o(boost),
    .volume_db_o(volume),
    .freq_strap_high_o(freq_hi),
    .i2c_scl_o(scl),
    .i2c_sda_o(sda)
  );

  // 250 MHz clock
  initial begin
    forever begin
      #2 clock = ~clock;
    end
  end

  // Compare one value against its expectation
  task automatic chk(input logic [7:0] seen, input logic [7:0] expected);
    n_checks++;
    if (seen !== expected) begin
      n_fail++;
      $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, expected);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Set the straps at a falling edge and let sync and ramp settle
  task automatic go(input logic [4:0] value);
    @(negedge clock);
    straps = value;
    repeat (12) @(negedge clock);
  endtask

  // Hold reset for six cycles with straps low
  task automatic do_reset();
    @(negedge clock);
    straps = 5'h00;
    rst = 1'h1;
    repeat (6) @(negedge clock);
    chk(8'(highz), 8'h01);
    chk(level, 8'h00);
    rst = 1'h0;
  endtask

  // Watchdog, far beyond the length of the tests
  initial begin
    #20000;
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end

  // Test sequence
  initial begin
    repeat (6) @(negedge clock);
    rst = 1'h0;
    // Gain codes
    go(5'h00);
    chk(8'(gsel), 8'(hcs_pkg::AGAIN_SEL_LOW));
    chk(dbv, hcs_pkg::AGAIN_LOW_DBV_X10);
    chk(8'(boost), 8'(hcs_pkg::BOOST_FIXED_DB));
    chk(volume, hcs_pkg::VOLUME_UNITY_DB);
    chk(8'(sw), 8'h00);
    chk(8'(scl), 8'h01);
    chk(8'(sda), 8'h01);
    chk(level, RAMP_FULL_EXP);
    chk(8'(path_act), 8'h01);
    go(5'h01);
    chk(8'(gsel), 8'(hcs_pkg::AGAIN_SEL_MID));
    chk(dbv, hcs_pkg::AGAIN_MID_DBV_X10);
    chk(8'(boost), 8'(hcs_pkg::BOOST_FIXED_DB));
    go(5'h02);
    chk(8'(gsel), 8'(hcs_pkg::AGAIN_SEL_HIGH));
    chk(dbv, hcs_pkg::AGAIN_HIGH_DBV_X10);
    chk(8'(boost), 8'(hcs_pkg::BOOST_FIXED_DB));
    chk(volume, hcs_pkg::VOLUME_UNITY_DB);
    $display("test gain done");
    // Bridge and frequency straps
    left_wanted = 1'h1;
    go(5'h10);
    chk(8'(pb), 8'h01);
    chk(8'(slot), 8'(hcs_pkg::SLOT_RIGHT));
    chk(8'(frame_invert), 8'h01);
    chk(8'(freq_hi), 8'h00);
    go(5'h08);
    chk(8'(pb), 8'h00);
    chk(8'(slot), 8'(hcs_pkg::SLOT_LEFT));
    chk(8'(freq_hi), 8'h01);
    left_wanted = 1'h0;
    $display("test bridge done");
    // Sleep and wake
    go(5'h04);
    chk(8'(sleep_act), 8'h01);
    chk(8'(highz), 8'h01);
    chk(8'(switching), 8'h00);
    chk(level, 8'h00);
    chk(8'(path_act), 8'h01);
    go(5'h00);
    chk(8'(highz), 8'h00);
    chk(8'(switching), 8'h01);
    chk(level, RAMP_FULL_EXP);
    // Host stops the audio and raises sleep first
    @(negedge clock);
    audio_stop = 1'h1;
    repeat (12) @(negedge clock);
    chk(8'(highz), 8'h01);
    @(negedge clock);
    audio_stop = 1'h0;
    repeat (12) @(negedge clock);
    chk(8'(switching), 8'h01);
    $display("test sleep done");
    // Software mode
    go(5'h1B);
    chk(8'(sw), 8'h01);
    chk(8'(pb), 8'h00);
    chk(8'(freq_hi), 8'h00);
    chk(8'(scl), 8'h01);
    chk(8'(sda), 8'h01);
    go(5'h03);
    chk(8'(scl), 8'h00);
    chk(8'(sda), 8'h00);
    go(5'h07);
    chk(8'(sleep_act), 8'h00);
    chk(8'(highz), 8'h00);
    $display("test software done");
    // Reset again in mid run
    do_reset();
    chk(8'(sw), 8'h00);
    repeat (12) @(negedge clock);
    chk(level, RAMP_FULL_EXP);
    chk(8'(switching), 8'h01);
    $display("test reset done");
    conclude();
  end
endmodule // tb
`default_nettype wire

// ==== logic/hcs_pkg.sv ====
`default_nettype none
package hcs_pkg;
  // Gain pin codes
  localparam logic [1:0] GAIN_LOW = 2'h0;
  localparam logic [1:0] GAIN_MID = 2'h1;
  localparam logic [1:0] GAIN_HIGH = 2'h2;
  localparam logic [1:0] GAIN_SOFTWARE = 2'h3;
  // Analog gain selection codes driven out
  localparam logic [1:0] AGAIN_SEL_LOW = 2'h0;
  localparam logic [1:0] AGAIN_SEL_MID = 2'h1;
  localparam logic [1:0] AGAIN_SEL_HIGH = 2'h2;
  // Analog gain in tenths of a dBV per setting
  localparam logic [7:0] AGAIN_LOW_DBV_X10 = 8'hC0;
  localparam logic [7:0] AGAIN_MID_DBV_X10 = 8'hE2;
  localparam logic [7:0] AGAIN_HIGH_DBV_X10 = 8'hFA;
  // Fixed digital boost, dB
  localparam logic [3:0] BOOST_FIXED_DB = 4'h6;
  // Fixed volume, dB attenuation code (unity)
  localparam logic [7:0] VOLUME_UNITY_DB = 8'h00;
  // Channel slot selection
  localparam logic SLOT_LEFT = 1'b0;
  localparam logic SLOT_RIGHT = 1'b1;
  // Reset values
  localparam logic [1:0] RST_GAIN_PINS = 2'h0;
  localparam logic RST_PIN_LEVEL = 1'b0;
  // Output stage states
  typedef enum logic [1:0] {
    OUT_RUN = 2'b00,
    OUT_RAMP_DOWN = 2'b01,
    OUT_HIGHZ = 2'b10,
    OUT_RAMP_UP = 2'b11
  } hcs_out_state_type;
  // Ramp length in cycles for graceful stop and restart
  localparam int RAMP_CYCLES = 16;
endpackage
`default_nettype wire

// ==== logic/hcs_strap_decoder.sv ====
// Overview of operation
// - Bridge pin high selects parallel bridge mode
// - Parallel bridge feeds amplifier from right slot
// - Sleep high ramps output to high impedance in hardware mode
// - Signal path stays active during sleep
// - Volume fixed at unity in hardware mode
// - Digital boost fixed for every gain
// - Gain codes 00/01/10 give low/mid/high
// - Gain code 11 enters software control mode
// - Software mode reassigns bridge and frequency pins
`default_nettype none
module hcs_strap_decoder #(
  parameter int RAMP_LEN = hcs_pkg::RAMP_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // Strap pins from the board
  input wire logic bridge_mode_clock_pin_i,
  input wire logic frequency_data_pin_i,
  input wire logic sleep_address_pin_i,
  input wire logic [1:0] gain_select_pins_i,
  // Decoded controls
  output logic software_mode_o,
  output logic parallel_bridge_mode_o,
  output logic channel_slot_o,
  output logic sleep_active_o,
  output logic output_switching_o,
  output logic output_highz_o,
  output logic signal_path_active_o,
  output logic [7:0] ramp_level_o,
  output logic [1:0] analog_gain_sel_o,
  output logic [7:0] analog_gain_dbv_x10_o,
  output logic [3:0] digital_boost_db_o,
  output logic [7:0] volume_db_o,
  output logic freq_strap_high_o,
  output logic i2c_scl_o,
  output logic i2c_sda_o
);
  // Synchroniser stages, first stage read only by second
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;

  // Position of each pin inside the synchronised word
  localparam int BRIDGE_BIT = 4;
  localparam int FREQ_BIT = 3;
  localparam int SLEEP_BIT = 2;

  // Ramp level at which the output stage runs at full drive
  localparam logic [7:0] RAMP_FULL = 8'(RAMP_LEN);
  // Level of the serial control lines while they carry nothing
  localparam logic LINE_IDLE = 1'h1;

  // Output stage state and ramp level
  hcs_pkg::hcs_out_state_type state_r;
  hcs_pkg::hcs_out_state_type state_nxt;
  logic [7:0] level_r;
  logic [7:0] level_nxt;

  // Registered copies of every decoded output
  logic software_mode_r;
  logic parallel_bridge_mode_r;
  logic channel_slot_r;
  logic sleep_active_r;
  logic output_switching_r;
  logic output_highz_r;
  logic signal_path_active_r;
  logic [1:0] analog_gain_sel_r;
  logic [7:0] analog_gain_dbv_x10_r;
  logic [3:0] digital_boost_db_r;
  logic [7:0] volume_db_r;
  logic freq_strap_high_r;
  logic i2c_scl_r;
  logic i2c_sda_r;

  // Named decode wires
  logic [1:0] gain_code_w;
  logic software_w;
  logic bridge_w;
  logic sleep_req_w;
  logic freq_w;
  logic slot_w;
  logic [1:0] gain_sel_w;
  logic [7:0] gain_dbv_w;
  logic highz_nxt_w;

  // Map a strap gain code onto the analog gain selection
  function automatic logic [1:0] gain_sel_of(input logic [1:0] code);
    logic [1:0] sel;
    sel = hcs_pkg::AGAIN_SEL_LOW;
    case (code)
      // Lowest gain
      hcs_pkg::GAIN_LOW: sel = hcs_pkg::AGAIN_SEL_LOW;
      // Middle gain
      hcs_pkg::GAIN_MID: sel = hcs_pkg::AGAIN_SEL_MID;
      // Highest gain
      hcs_pkg::GAIN_HIGH: sel = hcs_pkg::AGAIN_SEL_HIGH;
      // Software code: gain belongs to the serial port, park at lowest
      default: sel = hcs_pkg::AGAIN_SEL_LOW;
    endcase
    return sel;
  endfunction

  // Map a strap gain code onto its analog gain in tenths of a dBV
  function automatic logic [7:0] gain_dbv_of(input logic [1:0] code);
    logic [7:0] dbv;
    dbv = hcs_pkg::AGAIN_LOW_DBV_X10;
    case (code)
      // Lowest gain
      hcs_pkg::GAIN_LOW: dbv = hcs_pkg::AGAIN_LOW_DBV_X10;
      // Middle gain
      hcs_pkg::GAIN_MID: dbv = hcs_pkg::AGAIN_MID_DBV_X10;
      // Highest gain
      hcs_pkg::GAIN_HIGH: dbv = hcs_pkg::AGAIN_HIGH_DBV_X10;
      // Software code follows the parked selection
      default: dbv = hcs_pkg::AGAIN_LOW_DBV_X10;
    endcase
    return dbv;
  endfunction

  // Two flops on every strap pin, they come from the board asynchronously
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sync1_r <= {{3{hcs_pkg::RST_PIN_LEVEL}}, hcs_pkg::RST_GAIN_PINS};
      sync2_r <= {{3{hcs_pkg::RST_PIN_LEVEL}}, hcs_pkg::RST_GAIN_PINS};
    end else begin
      sync1_r <= {bridge_mode_clock_pin_i, frequency_data_pin_i, sleep_address_pin_i, gain_select_pins_i};
      sync2_r <= sync1_r;
    end
  end

  // Gain pins as seen after synchronisation
  assign gain_code_w = sync2_r[1:0];
  assign software_w = (gain_code_w == hcs_pkg::GAIN_SOFTWARE);
  assign bridge_w = !software_w && sync2_r[BRIDGE_BIT];
  assign slot_w = bridge_w ? hcs_pkg::SLOT_RIGHT : hcs_pkg::SLOT_LEFT;
  // sleep pin is a strap only in hardware mode
  assign sleep_req_w = !software_w && sync2_r[SLEEP_BIT];
  // frequency pin is a strap only in hardware mode
  assign freq_w = !software_w && sync2_r[FREQ_BIT];
  assign gain_sel_w = gain_sel_of(gain_code_w);
  assign gain_dbv_w = gain_dbv_of(gain_code_w);
  // The output stage is quiet once the state machine settles in high impedance
  assign highz_nxt_w = (state_nxt == hcs_pkg::OUT_HIGHZ);

  // graceful ramp into and out of high impedance
  always_comb begin
    state_nxt = state_r;
    level_nxt = level_r;
    case (state_r)
      // Full drive: leave only on a sleep request
      hcs_pkg::OUT_RUN: begin
        if (sleep_req_w) begin
          state_nxt = hcs_pkg::OUT_RAMP_DOWN;
        end
      end
      // Stepping down, turn back at once if sleep is withdrawn
      hcs_pkg::OUT_RAMP_DOWN: begin
        if (!sleep_req_w) begin
          state_nxt = hcs_pkg::OUT_RAMP_UP;
        end else if (level_r == 8'h00) begin
          state_nxt = hcs_pkg::OUT_HIGHZ;
        end else begin
          level_nxt = level_r - 8'h01;
        end
      end
      // Not switching; wait for sleep to drop
      hcs_pkg::OUT_HIGHZ: begin
        if (!sleep_req_w) begin
          state_nxt = hcs_pkg::OUT_RAMP_UP;
        end
      end
      // Stepping up, turn back at once on a new sleep request
      hcs_pkg::OUT_RAMP_UP: begin
        if (sleep_req_w) begin
          state_nxt = hcs_pkg::OUT_RAMP_DOWN;
        end else if (level_r >= RAMP_FULL) begin
          state_nxt = hcs_pkg::OUT_RUN;
        end else begin
          level_nxt = level_r + 8'h01;
        end
      end
      // Unknown code: fall back to the quiet state
      default: begin
        state_nxt = hcs_pkg::OUT_HIGHZ;
        level_nxt = 8'h00;
      end
    endcase
  end

  // Output stage registers; start quiet and ramp up after reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_r <= hcs_pkg::OUT_HIGHZ;
      level_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      level_r <= level_nxt;
    end
  end

  // Switching and high impedance flags follow the next state
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      output_switching_r <= 1'h0;
      output_highz_r <= 1'h1;
    end else begin
      output_switching_r <= !highz_nxt_w;
      output_highz_r <= highz_nxt_w;
    end
  end

  // signal path kept alive, sleep included
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      signal_path_active_r <= 1'h0;
      sleep_active_r <= 1'h0;
    end else begin
      signal_path_active_r <= 1'h1;
      sleep_active_r <= sleep_req_w;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      parallel_bridge_mode_r <= 1'h0;
      channel_slot_r <= hcs_pkg::SLOT_LEFT;
    end else begin
      parallel_bridge_mode_r <= bridge_w;
      channel_slot_r <= slot_w;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      software_mode_r <= 1'h0;
      analog_gain_sel_r <= hcs_pkg::AGAIN_SEL_LOW;
      analog_gain_dbv_x10_r <= hcs_pkg::AGAIN_LOW_DBV_X10;
    end else begin
      software_mode_r <= software_w;
      analog_gain_sel_r <= gain_sel_w;
      analog_gain_dbv_x10_r <= gain_dbv_w;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      digital_boost_db_r <= hcs_pkg::BOOST_FIXED_DB;
      volume_db_r <= hcs_pkg::VOLUME_UNITY_DB;
    end else begin
      digital_boost_db_r <= hcs_pkg::BOOST_FIXED_DB;
      volume_db_r <= hcs_pkg::VOLUME_UNITY_DB;
    end
  end

  // pins become serial clock and data
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      freq_strap_high_r <= 1'h0;
      i2c_scl_r <= LINE_IDLE;
      i2c_sda_r <= LINE_IDLE;
    end else begin
      freq_strap_high_r <= freq_w;
      // Lines idle high while the pins serve as straps
      i2c_scl_r <= software_w ? sync2_r[BRIDGE_BIT] : LINE_IDLE;
      i2c_sda_r <= software_w ? sync2_r[FREQ_BIT] : LINE_IDLE;
    end
  end

  // Every output straight from its flop
  assign software_mode_o = software_mode_r;
  assign parallel_bridge_mode_o = parallel_bridge_mode_r;
  assign channel_slot_o = channel_slot_r;
  assign sleep_active_o = sleep_active_r;
  assign output_switching_o = output_switching_r;
  assign output_highz_o = output_highz_r;
  assign signal_path_active_o = signal_path_active_r;
  assign ramp_level_o = level_r;
  assign analog_gain_sel_o = analog_gain_sel_r;
  assign analog_gain_dbv_x10_o = analog_gain_dbv_x10_r;
  assign digital_boost_db_o = digital_boost_db_r;
  assign volume_db_o = volume_db_r;
  assign freq_strap_high_o = freq_strap_high_r;
  assign i2c_scl_o = i2c_scl_r;
  assign i2c_sda_o = i2c_sda_r;
endmodule // hcs_strap_decoder
`default_nettype wire
